// ---- src/anpd_ctrl.sv ----
// Overview of operation
// - No FLP reply: parallel detect, clear partner-capable
// - Set partner ability bit for detected technology
// - Successful parallel detection sets negotiation complete
// - Enable detected datapath, disable all others
// - Only normal link pulses means 10M partner
// - Scrambled idles mean non-negotiating 100M partner
// - FLP reply sets partner-capable bit
// - No receive signal sets signal-detect bit
// - Multiple technologies: enable none, flag fault
// - Partner fault sets the remote-fault status bit
// - Own link fault advertises remote fault
// - Start negotiation at power-up and on request
// - Reset idles machines and clears progress bits
// - Restart reinitialises machines, keeps progress bits
// - Progress bits only rise without read/reset
// - After completion only read/reset alter bits
// - Link failure after completion restarts negotiation
// - Restart bit restarts, then clears itself
// - Enable bit one-zero-one restarts negotiation
// - Select pin high-low-high restarts negotiation
// - Negotiation normally finishes within 500 ms
// - Read returns old latch, then latches present
// - Progress code: complete bit, then 17.13..17.11
module anpd_ctrl
   import anpd_pkg::*;
#(
   parameter int unsigned FLP_WAIT  = FLP_WAIT_CYC,
   parameter int unsigned NEG_LIMIT = NEG_BUDGET_CYC
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       neg_enable_i,
   input  wire logic       restart_set_i,
   input  wire logic       hw_mode_i,
   input  wire logic       negotiation_select_pin_i,
   input  wire logic       rx_flp_i,
   input  wire logic       rx_nlp_i,
   input  wire logic       rx_idle100_i,
   input  wire logic       rx_any_i,
   input  wire logic       partner_fault_i,
   input  wire logic       local_fault_i,
   input  wire logic       link_ok_i,
   input  wire logic       flp_done_i,
   input  wire logic       status_read_i,
   output logic            restart_bit_o,
   output logic            partner_negotiation_capable_o,
   output logic            partner_10hd_o,
   output logic            partner_100hd_o,
   output logic            neg_complete_o,
   output logic            en_10_o,
   output logic            en_100_o,
   output logic            no_signal_o,
   output logic            pd_fault_o,
   output logic            remote_fault_o,
   output logic            adv_remote_fault_o,
   output logic [3:0]      progress_o,
   output logic            neg_overtime_o
);
   import anpd_pkg::*;

   logic       flp_s;
   logic       nlp_s;
   logic       idle_s;
   logic       any_s;
   logic       pfault_s;
   logic       lfault_s;
   logic       link_s;
   logic       sel_s;

   anpd_sync #(.W(8)) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({rx_flp_i, rx_nlp_i, rx_idle100_i, rx_any_i, partner_fault_i,
               local_fault_i, link_ok_i, negotiation_select_pin_i}),
      .q_o   ({flp_s, nlp_s, idle_s, any_s, pfault_s, lfault_s, link_s, sel_s})
   );

   function automatic logic [3:0] state_code(input anpd_state_e s);
      case (s)
         ANPD_IDLE:   state_code = PROG_IDLE;
         ANPD_LISTEN: state_code = PROG_LISTEN;
         ANPD_NEGOT:  state_code = PROG_FLP_SEEN;
         ANPD_PARDET: state_code = PROG_PAR_DET;
         ANPD_FAULT:  state_code = PROG_FAULT;
         ANPD_DONE:   state_code = PROG_COMPLETE;
         default:     state_code = PROG_IDLE;
      endcase
   endfunction

   anpd_state_e      st_q, st_d;
   logic [CNT_W-1:0] wait_q, wait_d;
   logic [CNT_W-1:0] neg_q, neg_d;
   logic             over_q, over_d;
   logic             rbit_q, rbit_d;
   logic             en_prev_q, en_prev_d;
   logic             sel_prev_q, sel_prev_d;
   logic             sel_high_q, sel_high_d;
   logic             link_prev_q, link_prev_d;
   logic             cap_q, cap_d;
   logic             p10_q, p10_d;
   logic             p100_q, p100_d;
   logic             cmp_q, cmp_d;
   logic [1:0]       tech_q, tech_d;
   logic             nosig_q, nosig_d;
   logic             pdf_q, pdf_d;
   logic             rf_q, rf_d;
   logic             arf_q, arf_d;
   logic [3:0]       prog_q, prog_d;
   logic [3:0]       shown_q, shown_d;
   logic             restart;
   logic [3:0]       cur_code;
   logic             multi;

   always_comb begin
      rbit_d      = rbit_q;
      en_prev_d   = neg_enable_i;
      sel_prev_d  = sel_s;
      sel_high_d  = sel_high_q || sel_s;
      link_prev_d = link_s;
      restart     = 1'b0;
      if (!hw_mode_i) begin
         if (restart_set_i || rbit_q) begin
            restart = 1'b1;
         end
         if (neg_enable_i && !en_prev_q) begin
            restart = 1'b1;
         end
      end else if (sel_s && !sel_prev_q && sel_high_q) begin
         restart = 1'b1;
      end
      if (link_prev_q && !link_s && st_q == ANPD_DONE) begin
         restart = 1'b1;
      end
      rbit_d = restart_set_i && !hw_mode_i;
   end

   always_comb begin
      st_d    = st_q;
      wait_d  = wait_q;
      neg_d   = neg_q;
      over_d  = over_q;
      cap_d   = cap_q;
      p10_d   = p10_q;
      p100_d  = p100_q;
      cmp_d   = cmp_q;
      tech_d  = tech_q;
      pdf_d   = pdf_q;
      nosig_d = !any_s;
      rf_d    = pfault_s;
      arf_d   = lfault_s;
      multi   = (nlp_s && idle_s) || (flp_s && (nlp_s || idle_s));
      if (st_q != ANPD_DONE && st_q != ANPD_IDLE && neg_q < CNT_W'(NEG_LIMIT)) begin
         neg_d = neg_q + 1'b1;
      end
      if (neg_q == CNT_W'(NEG_LIMIT) && st_q != ANPD_DONE) begin
         over_d = 1'b1;
      end
      case (st_q)
         ANPD_IDLE: begin
            if (neg_enable_i || hw_mode_i) begin
               st_d   = ANPD_LISTEN;
               wait_d = '0;
            end
         end
         ANPD_LISTEN: begin
            wait_d = wait_q + 1'b1;
            if (multi) begin
               st_d   = ANPD_FAULT;
               pdf_d  = 1'b1;
               tech_d = TECH_NONE;
            end else if (flp_s) begin
               st_d  = ANPD_NEGOT;
               cap_d = 1'b1;
            end else if (wait_q >= CNT_W'(FLP_WAIT) && (nlp_s || idle_s)) begin
               st_d = ANPD_PARDET;
            end
         end
         ANPD_NEGOT: begin
            if (flp_done_i) begin
               st_d  = ANPD_DONE;
               cmp_d = 1'b1;
            end
         end
         ANPD_PARDET: begin
            cap_d = 1'b0;
            if (nlp_s) begin
               p10_d  = 1'b1;
               tech_d = TECH_10;
            end else begin
               p100_d = 1'b1;
               tech_d = TECH_100;
            end
            cmp_d = 1'b1;
            st_d  = ANPD_DONE;
         end
         ANPD_FAULT: begin
            tech_d = TECH_NONE;
         end
         ANPD_DONE: begin
         end
         default: st_d = ANPD_IDLE;
      endcase
      if (restart) begin
         st_d   = ANPD_IDLE;
         wait_d = '0;
         neg_d  = '0;
         over_d = 1'b0;
         cmp_d  = 1'b0;
         tech_d = TECH_NONE;
      end
   end

   assign cur_code = state_code(st_q);

   always_comb begin
      prog_d  = prog_q;
      shown_d = shown_q;
      if (status_read_i) begin
         shown_d = prog_q;
         prog_d  = cur_code;
      end else if (prog_q != PROG_COMPLETE && cur_code > prog_q) begin
         prog_d  = cur_code;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q        <= ANPD_IDLE;
         wait_q      <= '0;
         neg_q       <= '0;
         over_q      <= 1'b0;
         rbit_q      <= 1'b0;
         en_prev_q   <= 1'b1;
         sel_prev_q  <= 1'b0;
         sel_high_q  <= 1'b0;
         link_prev_q <= 1'b0;
         cap_q       <= 1'b0;
         p10_q       <= 1'b0;
         p100_q      <= 1'b0;
         cmp_q       <= 1'b0;
         tech_q      <= TECH_NONE;
         nosig_q     <= 1'b0;
         pdf_q       <= 1'b0;
         rf_q        <= 1'b0;
         arf_q       <= 1'b0;
         prog_q      <= PROG_RST;
         shown_q     <= PROG_RST;
      end else begin
         st_q        <= st_d;
         wait_q      <= wait_d;
         neg_q       <= neg_d;
         over_q      <= over_d;
         rbit_q      <= rbit_d;
         en_prev_q   <= en_prev_d;
         sel_prev_q  <= sel_prev_d;
         sel_high_q  <= sel_high_d;
         link_prev_q <= link_prev_d;
         cap_q       <= cap_d;
         p10_q       <= p10_d;
         p100_q      <= p100_d;
         cmp_q       <= cmp_d;
         tech_q      <= tech_d;
         nosig_q     <= nosig_d;
         pdf_q       <= pdf_d;
         rf_q        <= rf_d;
         arf_q       <= arf_d;
         prog_q      <= prog_d;
         shown_q     <= shown_d;
      end
   end

   assign restart_bit_o                 = rbit_q;
   assign partner_negotiation_capable_o = cap_q;
   assign partner_10hd_o                = p10_q;
   assign partner_100hd_o               = p100_q;
   assign neg_complete_o                = cmp_q;
   assign en_10_o                       = (tech_q == TECH_10);
   assign en_100_o                      = (tech_q == TECH_100);
   assign no_signal_o                   = nosig_q;
   assign pd_fault_o                    = pdf_q;
   assign remote_fault_o                = rf_q;
   assign adv_remote_fault_o            = arf_q;
   assign progress_o                    = {cmp_q, shown_q[2:0]};
   assign neg_overtime_o                = over_q;

   a_pardet_complete: assert property (@(posedge clk_i) disable iff (rst_i)
      st_q == ANPD_PARDET && !restart |=> cmp_q && st_q == ANPD_DONE && !cap_q)
      else $error("parallel detect did not complete");
   a_flp_capable: assert property (@(posedge clk_i) disable iff (rst_i)
      st_q == ANPD_LISTEN && flp_s && !multi && !restart |=> cap_q)
      else $error("partner capable not set");
   a_fault_none: assert property (@(posedge clk_i) disable iff (rst_i)
      pdf_q && st_q == ANPD_FAULT |-> !en_10_o && !en_100_o)
      else $error("technology enabled on fault");
   a_one_tech: assert property (@(posedge clk_i) disable iff (rst_i)
      !(en_10_o && en_100_o) && (!en_10_o || p10_q) && (!en_100_o || p100_q))
      else $error("two technologies enabled");
   a_restart_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      rbit_q && !restart_set_i |=> !rbit_q ##1 (st_q == ANPD_IDLE || st_q == ANPD_LISTEN))
      else $error("restart bit not self cleared");
   a_prog_rise: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(status_read_i) && !status_read_i |-> prog_q >= $past(prog_q))
      else $error("progress bits fell");
   a_prog_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      prog_q == PROG_COMPLETE && !status_read_i |=> prog_q == PROG_COMPLETE)
      else $error("complete progress altered");
   a_read_latch: assert property (@(posedge clk_i) disable iff (rst_i)
      status_read_i |=> shown_q == $past(prog_q) && prog_q == $past(cur_code))
      else $error("read latch wrong");
   a_remote_fault: assert property (@(posedge clk_i) disable iff (rst_i)
      pfault_s |=> rf_q)
      else $error("remote fault not reported");
   a_restart_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      restart && !status_read_i |=> st_q == ANPD_IDLE && prog_q >= $past(prog_q))
      else $error("restart not to idle");
endmodule

// ---- src/anpd_pkg.sv ----
package anpd_pkg;
   localparam int unsigned CLK_MHZ          = 200;
   localparam int unsigned NEG_BUDGET_MS    = 500;
   localparam int unsigned NEG_BUDGET_CYC   = NEG_BUDGET_MS * 1000 * CLK_MHZ;
   localparam int unsigned FLP_WAIT_US      = 50;
   localparam int unsigned FLP_WAIT_CYC     = FLP_WAIT_US * CLK_MHZ;
   localparam int unsigned CNT_W            = 27;
   localparam logic [3:0]  PROG_RST         = 4'h0;
   localparam logic [3:0]  PROG_IDLE        = 4'h0;
   localparam logic [3:0]  PROG_LISTEN      = 4'h1;
   localparam logic [3:0]  PROG_FLP_SEEN    = 4'h2;
   localparam logic [3:0]  PROG_PAR_DET     = 4'h3;
   localparam logic [3:0]  PROG_ACK         = 4'h4;
   localparam logic [3:0]  PROG_FAULT       = 4'h5;
   localparam logic [3:0]  PROG_COMPLETE    = 4'hF;
   localparam logic [1:0]  TECH_NONE        = 2'h0;
   localparam logic [1:0]  TECH_10          = 2'h1;
   localparam logic [1:0]  TECH_100         = 2'h2;
   typedef enum logic [2:0] {
      ANPD_IDLE,
      ANPD_LISTEN,
      ANPD_NEGOT,
      ANPD_PARDET,
      ANPD_FAULT,
      ANPD_DONE
   } anpd_state_e;
endpackage

// ---- src/anpd_sync.sv ----
module anpd_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic [W-1:0]      q_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   always_comb begin
      meta_d = d_i;
      sync_d = meta_q;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign q_o = sync_q;
endmodule

// ---- tb/anpd_partner.sv ----
module anpd_partner (
   input  wire logic       clk_i,
   input  wire logic [2:0] mode_i,
   input  wire logic       fault_i,
   output logic            rx_flp_o,
   output logic            rx_nlp_o,
   output logic            rx_idle100_o,
   output logic            rx_any_o,
   output logic            partner_fault_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Modes: 0 silent, 1 legacy pulses, 2 100M idles, 3 negotiating, 4 mixed
   always_ff @(posedge clk_i) begin
      rx_flp_o        <= (mode_i == 3'h3);
      rx_nlp_o        <= (mode_i == 3'h1) || (mode_i == 3'h4);
      rx_idle100_o    <= (mode_i == 3'h2) || (mode_i == 3'h4);
      rx_any_o        <= (mode_i != 3'h0);
      partner_fault_o <= fault_i;
   end
endmodule

// ---- tb/anpd_ctrl_bench.sv ----
module anpd_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       neg_en = 1'b1, rs_set = 1'b0, hw_mode = 1'b0, sel_pin = 1'b1;
   logic       lfault = 1'b0, link_ok = 1'b0, flp_done = 1'b0, rd = 1'b0;
   logic [2:0] mode = 3'h0;
   logic       pfault_req = 1'b0;
   logic       flp, nlp, idl, any, pfault;
   logic       rbit, cap, p10, p100, done, e10, e100, nosig, pdf, rf, arf, ovt;
   logic [3:0] prog;
   logic [7:0] row_got;
   int         num_errors = 0;
   int         total_checks = 0;
   // Rows: partner mode, expected {cap,p10,p100,done,e10,e100,pdf,nosig}, mask
   logic [2:0] r_mode [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3};
   logic [7:0] r_exp  [5] = '{8'h01, 8'h58, 8'h34, 8'h02, 8'h90};
   logic [7:0] r_mask [5] = '{8'hF3, 8'hFF, 8'hFF, 8'h8E, 8'h93};

   anpd_partner part_u (.clk_i(clk_i), .mode_i(mode), .fault_i(pfault_req), .rx_flp_o(flp),
      .rx_nlp_o(nlp), .rx_idle100_o(idl), .rx_any_o(any), .partner_fault_o(pfault));

   anpd_ctrl #(.FLP_WAIT(20), .NEG_LIMIT(1000)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
      .neg_enable_i(neg_en), .restart_set_i(rs_set), .hw_mode_i(hw_mode),
      .negotiation_select_pin_i(sel_pin), .rx_flp_i(flp), .rx_nlp_i(nlp),
      .rx_idle100_i(idl), .rx_any_i(any), .partner_fault_i(pfault),
      .local_fault_i(lfault), .link_ok_i(link_ok), .flp_done_i(flp_done),
      .status_read_i(rd), .restart_bit_o(rbit), .partner_negotiation_capable_o(cap),
      .partner_10hd_o(p10), .partner_100hd_o(p100), .neg_complete_o(done),
      .en_10_o(e10), .en_100_o(e100), .no_signal_o(nosig), .pd_fault_o(pdf),
      .remote_fault_o(rf), .adv_remote_fault_o(arf), .progress_o(prog),
      .neg_overtime_o(ovt));

   initial begin
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic do_reset();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_i);
         mode     <= r_mode[i];
         flp_done <= (r_mode[i] == 3'h3);
         link_ok  <= (r_mode[i] != 3'h0);
         do_reset();
         wait_cyc(300);
         row_got = {cap, p10, p100, done, e10, e100, pdf, nosig} & r_mask[i];
         chk("outcome", r_exp[i] & r_mask[i], row_got);
         chk("overtime early", 8'h00, {7'h0, ovt});
         $display("row %0d done", i);
      end
      @(posedge clk_i);
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1;
      chk("progress complete", 8'h0F, {4'h0, prog});
      @(posedge clk_i);
      rs_set <= 1'b1;
      @(posedge clk_i);
      rs_set <= 1'b0;
      #1;
      chk("restart bit set", 8'h01, {7'h0, rbit});
      wait_cyc(1);
      chk("restart bit clear", 8'h00, {7'h0, rbit});
      @(posedge clk_i);
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1;
      chk("progress kept", 8'h07, {5'h0, prog[2:0]});
      $display("restart test done");
      wait_cyc(10);
      chk("complete polled", 8'h01, {7'h0, done});
      @(posedge clk_i);
      neg_en <= 1'b0;
      @(posedge clk_i);
      neg_en <= 1'b1;
      wait_cyc(1);
      chk("enable toggle restart", 8'h00, {7'h0, done});
      wait_cyc(10);
      @(posedge clk_i);
      hw_mode <= 1'b1;
      rs_set  <= 1'b1;
      @(posedge clk_i);
      rs_set  <= 1'b0;
      wait_cyc(3);
      chk("restart refused", 8'h01, {6'h0, rbit, done});
      @(posedge clk_i);
      sel_pin <= 1'b0;
      repeat (4) @(posedge clk_i);
      sel_pin <= 1'b1;
      wait_cyc(3);
      chk("select toggle restart", 8'h00, {7'h0, done});
      @(posedge clk_i);
      hw_mode <= 1'b0;
      wait_cyc(10);
      @(posedge clk_i);
      link_ok <= 1'b0;
      wait_cyc(3);
      chk("link failure restart", 8'h00, {7'h0, done});
      $display("restart sources test done");
      @(posedge clk_i);
      flp_done <= 1'b0;
      link_ok  <= 1'b1;
      do_reset();
      wait_cyc(20);
      @(posedge clk_i);
      mode <= 3'h0;
      wait_cyc(5);
      @(posedge clk_i);
      rs_set <= 1'b1;
      @(posedge clk_i);
      rs_set <= 1'b0;
      wait_cyc(10);
      @(posedge clk_i);
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1;
      chk("first read history", 8'h02, {4'h0, prog});
      @(posedge clk_i);
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1;
      chk("second read present", 8'h01, {4'h0, prog});
      wait_cyc(1000);
      chk("overtime flagged", 8'h01, {7'h0, ovt});
      $display("progress test done");
      @(posedge clk_i);
      pfault_req <= 1'b1;
      lfault     <= 1'b1;
      wait_cyc(10);
      chk("remote fault", 8'h01, {7'h0, rf});
      chk("advertised fault", 8'h01, {7'h0, arf});
      $display("fault test done");
      @(posedge clk_i);
      rst_i <= 1'b1;
      wait_cyc(2);
      chk("progress in reset", 8'h00, {4'h0, prog});
      chk("complete in reset", 8'h00, {7'h0, done});
      @(posedge clk_i);
      rst_i <= 1'b0;
      $display("reset test done");
      results();
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      $display("MISMATCH watchdog expected finish seen hang");
      results();
   end
endmodule
